//--- inc/sar_ctl_pkg.sv
// Constants shared by the converter control block and its approximation engine.
// Assumes one 50 MHz core clock; all converter timing is counted in enable ticks.
package sar_ctl_pkg;

   // Core clock and the suggested converter clock
   localparam int CORE_CLK_MHZ       = 50;
   localparam int CONV_CLK_TARGET_NS = 1000;
   localparam int CONV_CLK_TARGET_CY = (CONV_CLK_TARGET_NS * CORE_CLK_MHZ) / 1000;

   // Result and channel geometry
   localparam int RES_W  = 10;
   localparam int CHAN_W = 5;
   localparam int NUM_CH = 24;

   // Channel select codes
   localparam logic [4:0] CHAN_UPPER_REF = 5'h1D;
   localparam logic [4:0] CHAN_LOWER_REF = 5'h1E;
   localparam logic [4:0] CHAN_POWER_OFF = 5'h1F;

   // Conversion sequence, in converter clock ticks
   localparam logic [4:0] CONV_SAMPLE_TICKS = 5'h04;
   localparam logic [4:0] CONV_BIT_TICKS    = 5'h0A;
   localparam logic [4:0] CONV_TOTAL_TICKS  = 5'h10;

   // Approximation engine start values
   localparam logic [9:0] SAR_FIRST_TRIAL = 10'h200;
   localparam logic [3:0] SAR_MSB_INDEX   = 4'h9;

   // Divider field: ratio is two to the power of the field, capped
   localparam logic [2:0] CLK_DIV_MAX = 3'h4;

   // Reset values
   localparam logic [4:0] RST_CHAN    = CHAN_POWER_OFF;
   localparam logic [2:0] RST_CLK_DIV = 3'h0;
   localparam logic       RST_CLK_SRC = 1'b0;

   // Result formats
   typedef enum logic [1:0] {
      FMT_LEFT   = 2'h0,
      FMT_RIGHT  = 2'h1,
      FMT_SIGNED = 2'h2,
      FMT_TRUNC  = 2'h3
   } fmt_e;

   localparam fmt_e RST_FMT = FMT_LEFT;

endpackage

//--- src/sar_engine.sv
// Successive approximation register: trial code out, comparator decision in.
// Assumes the comparator level is already synchronised to the core clock.
`timescale 1ns/1ps
module sar_engine (
   // Clock and reset
   input  wire logic             core_clk_i,
   input  wire logic             srst_i,
   // Sequencing
   input  wire logic             clear_i,
   input  wire logic             step_i,
   input  wire logic             comp_i,
   // Trial and result code
   output logic [9:0]            code_o
);

   logic [3:0] ptr_q;

   // Trial bit kept when the input is at or above the trial level
   always_ff @(posedge core_clk_i) begin
      if (srst_i || clear_i) begin
         code_o <= sar_ctl_pkg::SAR_FIRST_TRIAL;
         ptr_q  <= sar_ctl_pkg::SAR_MSB_INDEX;
      end else if (step_i) begin
         code_o[ptr_q] <= comp_i;
         if (ptr_q != 4'h0) begin
            code_o[ptr_q - 4'h1] <= 1'b1;
            ptr_q                <= ptr_q - 4'h1;
         end
      end
   end

   a_first_trial: assert property (@(posedge core_clk_i) disable iff (srst_i)
      clear_i |=> code_o == 10'h200)
      else $error("first trial is not mid-scale");

endmodule

//--- src/sar_adc_control.sv
// Digital control for a 10-bit successive approximation converter, 24 inputs.
// Assumes register strobes come from the core clock domain; pins and the
// comparator are asynchronous and are synchronised here.
`timescale 1ns/1ps
module sar_adc_control (
   // Clock and reset
   input  wire logic              core_clk_i,
   input  wire logic              srst_i,
   // Status/control register write
   input  wire logic              scr_wr_i,
   input  wire logic              scr_int_en_i,
   input  wire logic              scr_cont_i,
   input  wire logic [4:0]        scr_chan_i,
   // Clock/format register write
   input  wire logic              clk_wr_i,
   input  wire logic [2:0]        clk_div_i,
   input  wire logic              clk_src_i,
   input  wire logic [1:0]        fmt_i,
   input  wire logic              alt_clk_tick_i,
   // Result register reads
   input  wire logic              rd_high_i,
   input  wire logic              rd_low_i,
   output logic [7:0]             result_high_o,
   output logic [7:0]             result_low_o,
   // Status
   output logic                   complete_flag_o,
   output logic                   int_en_o,
   output logic                   cont_o,
   output logic [4:0]             chan_o,
   output logic [2:0]             clk_div_o,
   output logic                   clk_src_o,
   output logic [1:0]             fmt_o,
   output logic                   busy_o,
   // Low-power and interrupt
   input  wire logic              stop_i,
   input  wire logic              wait_i,
   output logic                   irq_o,
   output logic                   wake_o,
   // Port pins shared with the converter
   input  wire logic [23:0]       port_out_i,
   input  wire logic [23:0]       port_dir_i,
   input  wire logic [23:0]       pin_in_i,
   output logic [23:0]            pin_out_o,
   output logic [23:0]            pin_oe_n_o,
   output logic [23:0]            port_read_o,
   // Analog front end
   input  wire logic              comp_i,
   output logic [4:0]             mux_sel_o,
   output logic [9:0]             dac_code_o,
   output logic                   sample_o,
   output logic                   power_en_o
);

   typedef enum logic [1:0] {ST_IDLE, ST_ALIGN, ST_RUN} conv_state_e;

   conv_state_e state_q;
   logic        int_en_q, cont_q, src_q, start_q, flag_q, lock_q;
   logic [4:0]  chan_q, tick_n_q, span_q;
   logic [2:0]  div_q;
   logic [1:0]  fmt_q;
   logic [3:0]  pre_q;
   logic        tick, done, powered, src_tick, sar_clear, sar_step;
   logic [23:0] pin_s1_q, pin_s2_q, sel_mask;
   logic        comp_s1_q, comp_s2_q;
   logic [9:0]  code;

   // One-hot mask of the pin taken by the converter
   function automatic logic [23:0] chan_mask(input logic [4:0] ch);
      chan_mask = '0;
      if (ch < 5'(sar_ctl_pkg::NUM_CH)) begin
         chan_mask[ch] = 1'b1;
      end
   endfunction

   // Places a raw result into the high and low register images
   function automatic logic [15:0] fmt_result(input logic [1:0] f, input logic [9:0] r);
      unique case (sar_ctl_pkg::fmt_e'(f))
         sar_ctl_pkg::FMT_LEFT:   fmt_result = {r[9:2], r[1:0], 6'h00};
         sar_ctl_pkg::FMT_RIGHT:  fmt_result = {6'h00, r[9:8], r[7:0]};
         sar_ctl_pkg::FMT_SIGNED: fmt_result = {~r[9], r[8:2], r[1:0], 6'h00};
         sar_ctl_pkg::FMT_TRUNC:  fmt_result = {8'h00, r[9:2]};
      endcase
   endfunction

   assign powered  = chan_q != sar_ctl_pkg::CHAN_POWER_OFF;
   assign sel_mask = chan_mask(chan_q);

   // Control register fields
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         int_en_q <= 1'b0;
         cont_q   <= 1'b0;
         chan_q   <= sar_ctl_pkg::RST_CHAN;
      end else if (scr_wr_i) begin
         int_en_q <= scr_int_en_i;
         cont_q   <= scr_cont_i;
         chan_q   <= scr_chan_i;
      end
   end

   // Clock and format register fields
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         div_q <= sar_ctl_pkg::RST_CLK_DIV;
         src_q <= sar_ctl_pkg::RST_CLK_SRC;
         fmt_q <= sar_ctl_pkg::RST_FMT;
      end else if (clk_wr_i) begin
         div_q <= clk_div_i;
         src_q <= clk_src_i;
         fmt_q <= fmt_i;
      end
   end

   // Converter clock enable: source select then power-of-two divider
   assign src_tick = src_q ? 1'b1 : alt_clk_tick_i;
   assign tick     = src_tick && ((div_q >= sar_ctl_pkg::CLK_DIV_MAX) ? (pre_q == 4'hF)
                                   : (pre_q >= 4'((5'h01 << div_q) - 5'h01)));

   always_ff @(posedge core_clk_i) begin
      if (srst_i || stop_i) begin
         pre_q <= 4'h0;
      end else if (tick) begin
         pre_q <= 4'h0;
      end else if (src_tick) begin
         pre_q <= pre_q + 4'h1;
      end
   end

   // Synchronisers for pins and comparator
   always_ff @(posedge core_clk_i) begin
      pin_s1_q  <= pin_in_i;
      pin_s2_q  <= pin_s1_q;
      comp_s1_q <= comp_i;
      comp_s2_q <= comp_s1_q;
   end

   // Port override of the selected pin
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         pin_out_o   <= '0;
         pin_oe_n_o  <= '1;
         port_read_o <= '0;
      end else begin
         pin_out_o   <= port_out_i & ~sel_mask;
         pin_oe_n_o  <= ~(port_dir_i & ~sel_mask);
         port_read_o <= pin_s2_q & ~sel_mask;
      end
   end

   // Pending start request
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         start_q <= 1'b0;
      end else if (scr_wr_i) begin
         start_q <= scr_chan_i != sar_ctl_pkg::CHAN_POWER_OFF;
      end else if (stop_i && state_q != ST_IDLE) begin
         start_q <= 1'b1;
      end else if (state_q == ST_IDLE && !stop_i) begin
         start_q <= 1'b0;
      end
   end

   // Conversion sequencer
   assign done = state_q == ST_RUN && tick && tick_n_q == sar_ctl_pkg::CONV_TOTAL_TICKS - 5'h01;

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         state_q  <= ST_IDLE;
         tick_n_q <= '0;
      end else if (stop_i || scr_wr_i) begin
         state_q  <= ST_IDLE;
         tick_n_q <= '0;
      end else begin
         unique case (state_q)
            ST_IDLE: if (start_q && powered) begin
               state_q <= ST_ALIGN;
            end
            ST_ALIGN: if (tick) begin
               state_q  <= ST_RUN;
               tick_n_q <= '0;
            end
            ST_RUN: if (done) begin
               tick_n_q <= '0;
               state_q  <= (cont_q && powered) ? ST_RUN : ST_IDLE;
            end else if (tick) begin
               tick_n_q <= tick_n_q + 5'h01;
            end
         endcase
      end
   end

   assign sar_clear = state_q == ST_ALIGN || (done && cont_q);
   assign sar_step  = state_q == ST_RUN && tick && tick_n_q >= sar_ctl_pkg::CONV_SAMPLE_TICKS
                      && tick_n_q < sar_ctl_pkg::CONV_SAMPLE_TICKS + sar_ctl_pkg::CONV_BIT_TICKS;

   sar_engine u_sar (
      .core_clk_i (core_clk_i),
      .srst_i     (srst_i),
      .clear_i    (sar_clear),
      .step_i     (sar_step),
      .comp_i     (comp_s2_q),
      .code_o     (code)
   );

   // High read locks the pair in the interlocked formats
   always_ff @(posedge core_clk_i) begin
      if (srst_i || rd_low_i) begin
         lock_q <= 1'b0;
      end else if (rd_high_i && fmt_q != sar_ctl_pkg::FMT_TRUNC) begin
         lock_q <= 1'b1;
      end
   end

   // Result store, overwriting unread data unless locked
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         result_high_o <= '0;
         result_low_o  <= '0;
      end else if (done && !(lock_q && fmt_q != sar_ctl_pkg::FMT_TRUNC)) begin
         {result_high_o, result_low_o} <= fmt_result(fmt_q, code);
      end
   end

   // Completion flag: set wins over the read that clears it
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         flag_q <= 1'b0;
      end else if (done && !int_en_q) begin
         flag_q <= 1'b1;
      end else if (rd_high_i || rd_low_i) begin
         flag_q <= 1'b0;
      end
   end

   // Interrupt request: set wins over read or control write
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         irq_o <= 1'b0;
      end else if (done && int_en_q) begin
         irq_o <= 1'b1;
      end else if (rd_high_i || rd_low_i || scr_wr_i) begin
         irq_o <= 1'b0;
      end
   end

   // Span of the current conversion in ticks, for checking
   always_ff @(posedge core_clk_i) begin
      if (srst_i || state_q == ST_IDLE || done) begin
         span_q <= '0;
      end else if (tick) begin
         span_q <= span_q + 5'h01;
      end
   end

   // Status and analog outputs
   assign complete_flag_o = flag_q && !int_en_q;
   assign wake_o          = irq_o && wait_i;
   assign int_en_o        = int_en_q;
   assign cont_o          = cont_q;
   assign chan_o          = chan_q;
   assign clk_div_o       = div_q;
   assign clk_src_o       = src_q;
   assign fmt_o           = fmt_q;
   assign busy_o          = state_q != ST_IDLE;
   assign mux_sel_o       = chan_q;
   assign dac_code_o      = code;
   assign sample_o        = state_q == ST_RUN && tick_n_q < sar_ctl_pkg::CONV_SAMPLE_TICKS;
   assign power_en_o      = powered && !stop_i;

   a_sel_pin_input: assert property (@(posedge core_clk_i) disable iff (srst_i)
      sel_mask[3] && $stable(chan_q) |=> pin_oe_n_o[3] && !port_read_o[3])
      else $error("selected pin not released to converter");

   a_unsel_port: assert property (@(posedge core_clk_i) disable iff (srst_i)
      !$past(srst_i) && !sel_mask[0] && !$past(sel_mask[0]) |-> pin_out_o[0] == $past(port_out_i[0]))
      else $error("unselected pin lost port control");

   a_write_starts: assert property (@(posedge core_clk_i) disable iff (srst_i)
      scr_wr_i && scr_chan_i != 5'h1F && !stop_i ##1 !scr_wr_i && !stop_i |=> state_q == ST_ALIGN)
      else $error("control write did not start a conversion");

   a_conv_ticks: assert property (@(posedge core_clk_i) disable iff (srst_i)
      done |-> span_q == 5'h0F || span_q == 5'h10)
      else $error("conversion length outside 16 to 17 ticks");

   a_flag_hold: assert property (@(posedge core_clk_i) disable iff (srst_i)
      $fell(flag_q) |-> $past(rd_high_i || rd_low_i))
      else $error("completion flag cleared without a read");

   a_cont_repeat: assert property (@(posedge core_clk_i) disable iff (srst_i)
      done && cont_q && powered && !scr_wr_i && !stop_i |=> state_q == ST_RUN && tick_n_q == 5'h00)
      else $error("continuous mode did not restart");

   a_single_idle: assert property (@(posedge core_clk_i) disable iff (srst_i)
      done && !cont_q && !scr_wr_i && !stop_i |=> state_q == ST_IDLE && !start_q)
      else $error("single mode did not idle");

   a_low_frozen: assert property (@(posedge core_clk_i) disable iff (srst_i)
      lock_q && !rd_low_i |=> $stable(result_low_o))
      else $error("low result changed while locked");

   a_fmt_store: assert property (@(posedge core_clk_i) disable iff (srst_i)
      done && !lock_q |=> {result_high_o, result_low_o} == fmt_result($past(fmt_q), $past(code)))
      else $error("stored result has wrong format");

   a_irq_on_done: assert property (@(posedge core_clk_i) disable iff (srst_i)
      done && int_en_q |=> irq_o && !complete_flag_o)
      else $error("no interrupt after conversion");

   a_irq_clear: assert property (@(posedge core_clk_i) disable iff (srst_i)
      irq_o && scr_wr_i && !done |=> !irq_o)
      else $error("interrupt not removed by control write");

   a_stop_abort: assert property (@(posedge core_clk_i) disable iff (srst_i)
      stop_i && busy_o |=> state_q == ST_IDLE && start_q)
      else $error("stop did not abort and keep the restart");

endmodule

//--- testbench/tb_top.sv
// Self-checking bench for the converter control block, driving its ports directly.
// Assumes one-cycle strobes sampled on the rising core clock edge; a comparator
// model answers from the selected channel's level against the trial code.
`timescale 1ns/1ps
module tb_top;
   // Design inputs, all given a value at time zero
   logic        core_clk_i = 1'b0;
   logic        srst_i     = 1'b1;
   logic        scr_wr     = 1'b0;
   logic        ie         = 1'b0;
   logic        cont       = 1'b0;
   logic [4:0]  ch         = 5'h1F;
   logic        clk_wr     = 1'b0;
   logic [2:0]  div        = 3'h0;
   logic        src        = 1'b0;
   logic [1:0]  fmt        = 2'h0;
   logic        alt_tick   = 1'b0;
   logic [4:0]  tick_cnt   = 5'h00;
   logic        rd_hi      = 1'b0;
   logic        rd_lo      = 1'b0;
   logic        stop       = 1'b0;
   logic        wt         = 1'b0;
   logic        comp       = 1'b0;
   logic [23:0] p_out      = 24'h000000;
   logic [23:0] p_dir      = 24'h000000;
   logic [23:0] p_in       = 24'h000000;
   logic [9:0]  ofs        = 10'h2AA;
   // Design outputs
   logic [7:0]  res_hi;
   logic [7:0]  res_lo;
   logic        flag;
   logic        ie_rb;
   logic        cont_rb;
   logic [4:0]  chan_rb;
   logic [2:0]  div_rb;
   logic        src_rb;
   logic [1:0]  fmt_rb;
   logic        busy;
   logic        irq;
   logic        wake;
   logic [23:0] pin_out;
   logic [23:0] pin_oe_n;
   logic [23:0] port_rd;
   logic [4:0]  mux_sel;
   logic [9:0]  dac;
   logic        sample;
   logic        pwr;
   int          n_fail       = 0;
   int          total_checks = 0;
   int          cyc;
   logic [7:0]  v;

   sar_adc_control u_dut (
      .core_clk_i(core_clk_i), .srst_i(srst_i), .scr_wr_i(scr_wr), .scr_int_en_i(ie), .scr_cont_i(cont),
      .scr_chan_i(ch), .clk_wr_i(clk_wr), .clk_div_i(div), .clk_src_i(src), .fmt_i(fmt),
      .alt_clk_tick_i(alt_tick), .rd_high_i(rd_hi), .rd_low_i(rd_lo), .result_high_o(res_hi),
      .result_low_o(res_lo), .complete_flag_o(flag), .int_en_o(ie_rb), .cont_o(cont_rb), .chan_o(chan_rb),
      .clk_div_o(div_rb), .clk_src_o(src_rb), .fmt_o(fmt_rb), .busy_o(busy), .stop_i(stop), .wait_i(wt),
      .irq_o(irq), .wake_o(wake), .port_out_i(p_out), .port_dir_i(p_dir), .pin_in_i(p_in),
      .pin_out_o(pin_out), .pin_oe_n_o(pin_oe_n), .port_read_o(port_rd), .comp_i(comp),
      .mux_sel_o(mux_sel), .dac_code_o(dac), .sample_o(sample), .power_en_o(pwr));

   // Core clock, 20 ns period
   always #10 core_clk_i = ~core_clk_i;

   // Alternate converter clock: one tick every twenty-five core cycles
   always @(negedge core_clk_i) begin
      tick_cnt <= (tick_cnt == 5'h18) ? 5'h00 : tick_cnt + 5'h01;
      alt_tick <= (tick_cnt == 5'h18);
   end

   // Level on each channel: references at the rails, pins from the channel number plus offset
   function automatic logic [9:0] vin_of(input logic [4:0] c);
      if (c == sar_ctl_pkg::CHAN_UPPER_REF) return 10'h3FF;
      if (c == sar_ctl_pkg::CHAN_LOWER_REF) return 10'h000;
      return {c, 5'h0B} + ofs;
   endfunction

   // Comparator model: high while the input is at or above the trial code
   always @(negedge core_clk_i) comp <= (vin_of(mux_sel) >= dac);

   // Expected {high, low} register pair for a format and a code
   function automatic logic [15:0] fmt_exp(input logic [1:0] f, input logic [9:0] c);
      case (f)
         2'h0:    return {c[9:2], c[1:0], 6'h00};
         2'h1:    return {6'h00, c[9:8], c[7:0]};
         2'h2:    return {~c[9], c[8:2], c[1:0], 6'h00};
         default: return {8'h00, c[9:2]};
      endcase
   endfunction

   task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic step(input int n);
      repeat (n) @(negedge core_clk_i);
   endtask

   // Status/control write: one-cycle strobe with its fields
   task automatic wr_scr(input logic i, input logic c, input logic [4:0] n);
      ie = i;
      cont = c;
      ch = n;
      scr_wr = 1'b1;
      step(1);
      scr_wr = 1'b0;
   endtask

   // Clock/format write: one-cycle strobe with its fields
   task automatic wr_clk(input logic [2:0] d, input logic s, input logic [1:0] f);
      div = d;
      src = s;
      fmt = f;
      clk_wr = 1'b1;
      step(1);
      clk_wr = 1'b0;
   endtask

   // Result read: value taken at the strobe, strobe held one cycle, then one idle
   // cycle so that back-to-back reads never change a strobe twice in one step
   task automatic rd(input logic hi, output logic [7:0] val);
      val = hi ? res_hi : res_lo;
      rd_hi = hi;
      rd_lo = ~hi;
      step(1);
      rd_hi = 1'b0;
      rd_lo = 1'b0;
      step(1);
   endtask

   // Waits out one single conversion; cycles counted from the strobe edge
   task automatic conv(output int n);
      step(3);
      n = 3;
      while (busy === 1'b1 && n < 1200) begin
         step(1);
         n++;
      end
      if (n >= 1200) begin
         n_fail++;
         $display("[ERR] %0t conversion never ended", $time);
      end
      step(2);
   endtask

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   // Watchdog: the tests need a few thousand cycles
   initial begin
      repeat (20000) @(posedge core_clk_i);
      n_fail++;
      $display("[ERR] %0t watchdog expired", $time);
      tally_and_finish();
   end

   // Test sequence
   initial begin
      step(20);
      srst_i = 1'b0;
      chk({res_hi, res_lo}, 16'h0000, "reset results");
      chk({flag, irq, busy}, 3'h0, "reset flags");
      chk(chan_rb, sar_ctl_pkg::RST_CHAN, "reset channel");
      chk(pin_oe_n, 24'hFFFFFF, "reset pin enables");
      chk(dac, sar_ctl_pkg::SAR_FIRST_TRIAL, "reset trial code");
      $display("test reset finished");
      // Every result format, core clock divided by four
      for (int f = 0; f < 4; f++) begin
         wr_clk(3'h2, 1'b1, f[1:0]);
         chk({div_rb, src_rb, fmt_rb}, {3'h2, 1'b1, f[1:0]}, "clock/format readback");
         wr_scr(1'b0, 1'b0, 5'h03);
         conv(cyc);
         chk(24'(cyc >= 16 * 4 && cyc <= 17 * 4 + 4), 24'h1, "conversion length");
         chk(flag, 1'b1, "flag at end");
         chk({res_hi, res_lo}, fmt_exp(f[1:0], vin_of(5'h03)), "formatted result");
         rd(1'b1, v);
         rd(1'b0, v);
         step(1);
         chk(flag, 1'b0, "flag after read");
      end
      $display("test formats finished");
      // References through the alternate clock halved to 1 MHz, then power off
      wr_clk(3'h1, 1'b0, 2'h1);
      wr_scr(1'b0, 1'b0, sar_ctl_pkg::CHAN_UPPER_REF);
      conv(cyc);
      chk({res_hi, res_lo}, 16'h03FF, "upper reference");
      chk(24'(cyc >= 16 * 50 && cyc <= 17 * 50 + 50), 24'h1, "length at 1 MHz");
      rd(1'b1, v);
      rd(1'b0, v);
      wr_scr(1'b0, 1'b0, sar_ctl_pkg::CHAN_LOWER_REF);
      conv(cyc);
      chk({res_hi, res_lo}, 16'h0000, "lower reference");
      rd(1'b1, v);
      rd(1'b0, v);
      wr_scr(1'b0, 1'b0, sar_ctl_pkg::CHAN_POWER_OFF);
      step(10);
      chk({busy, pwr}, 2'h0, "power off");
      $display("test references finished");
      // High read locks results until the low read
      wr_clk(3'h2, 1'b1, 2'h0);
      wr_scr(1'b0, 1'b0, 5'h03);
      conv(cyc);
      rd(1'b1, v);
      chk(v, fmt_exp(2'h0, vin_of(5'h03)) >> 8, "high before lock");
      ofs = 10'h2AB;
      wr_scr(1'b0, 1'b0, 5'h03);
      conv(cyc);
      ofs = 10'h2AA;
      chk({res_hi, res_lo}, fmt_exp(2'h0, vin_of(5'h03)), "locked result");
      rd(1'b0, v);
      ofs = 10'h2AB;
      wr_scr(1'b0, 1'b0, 5'h03);
      conv(cyc);
      chk({res_hi, res_lo}, fmt_exp(2'h0, vin_of(5'h03)), "result after unlock");
      rd(1'b1, v);
      rd(1'b0, v);
      $display("test interlock finished");
      // Interrupt, wake and its removal
      wr_scr(1'b1, 1'b0, 5'h03);
      conv(cyc);
      chk({irq, flag, ie_rb}, 3'h5, "interrupt at end");
      wt = 1'b1;
      step(1);
      chk(wake, 1'b1, "wake in wait");
      rd(1'b0, v);
      step(1);
      chk(irq, 1'b0, "interrupt after read");
      wr_scr(1'b1, 1'b0, 5'h03);
      conv(cyc);
      chk(irq, 1'b1, "interrupt in wait");
      wr_scr(1'b1, 1'b0, 5'h03);
      chk(irq, 1'b0, "interrupt after write");
      conv(cyc);
      wt = 1'b0;
      wr_scr(1'b0, 1'b0, 5'h03);
      conv(cyc);
      rd(1'b1, v);
      rd(1'b0, v);
      wr_scr(1'b0, 1'b0, sar_ctl_pkg::CHAN_POWER_OFF);
      wt = 1'b1;
      step(5);
      chk({busy, pwr, wake}, 3'h0, "powered down in wait");
      wt = 1'b0;
      $display("test interrupt finished");
      // Continuous truncated results overwrite without reads
      wr_clk(3'h2, 1'b1, 2'h3);
      rd(1'b1, v);
      wr_scr(1'b0, 1'b1, 5'h07);
      step(90);
      chk({res_hi, res_lo}, fmt_exp(2'h3, vin_of(5'h07)), "first continuous result");
      ofs = 10'h155;
      step(150);
      chk({res_hi, res_lo}, fmt_exp(2'h3, vin_of(5'h07)), "overwritten result");
      chk({busy, cont_rb, flag}, 3'h7, "still converting");
      wr_scr(1'b0, 1'b0, 5'h07);
      conv(cyc);
      step(150);
      chk(busy, 1'b0, "idle after single");
      $display("test continuous finished");
      // Selected pin taken from the port
      p_dir = 24'hFFFFFF;
      p_out = 24'hA5A5A5;
      p_in = 24'hFFFFFF;
      wr_scr(1'b0, 1'b0, 5'h05);
      step(5);
      chk({sample, dac}, {1'b1, sar_ctl_pkg::SAR_FIRST_TRIAL}, "sampling at mid-scale");
      chk(mux_sel, 5'h05, "mux follows channel");
      chk(pin_oe_n, 24'h000020, "selected pin not driven");
      chk(pin_out, 24'hA5A585, "port drives unselected pins only");
      chk(port_rd, 24'hFFFFDF, "selected pin reads zero");
      conv(cyc);
      $display("test pins finished");
      // Stop aborts, then the conversion restarts
      wr_clk(3'h2, 1'b1, 2'h0);
      rd(1'b1, v);
      rd(1'b0, v);
      wr_scr(1'b0, 1'b0, 5'h03);
      step(20);
      stop = 1'b1;
      step(2);
      chk({busy, pwr}, 2'h0, "stopped");
      step(50);
      chk(busy, 1'b0, "still stopped");
      stop = 1'b0;
      conv(cyc);
      chk({res_hi, res_lo}, fmt_exp(2'h0, vin_of(5'h03)), "result after stop");
      rd(1'b1, v);
      rd(1'b0, v);
      wr_scr(1'b0, 1'b0, 5'h03);
      conv(cyc);
      chk({res_hi, res_lo}, fmt_exp(2'h0, vin_of(5'h03)), "settled result");
      rd(1'b1, v);
      rd(1'b0, v);
      $display("test stop finished");
      // Write mid conversion restarts with the new channel
      wr_scr(1'b0, 1'b0, 5'h03);
      step(30);
      wr_scr(1'b0, 1'b0, 5'h09);
      conv(cyc);
      chk(24'(cyc >= 16 * 4 && cyc <= 17 * 4 + 4), 24'h1, "restarted length");
      chk({res_hi, res_lo}, fmt_exp(2'h0, vin_of(5'h09)), "restarted result");
      $display("test restart finished");
      tally_and_finish();
   end
endmodule
